// File: hdl/reg_tlv_pkg.sv
// Purpose: shared constants for registration response / acknowledge tlv logic
// Assumes: one octet per cycle on byte streams
// Notes:   type and length fields are one octet each
`default_nettype none
package reg_tlv_pkg;
    localparam logic [7:0] CONF_OK          = 8'h00;
    localparam logic [7:0] CONF_AUTH_FAIL   = 8'h01;
    localparam logic [7:0] CONF_COS_FAIL    = 8'h02;
    localparam logic [7:0] CONF_REJECT      = 8'h0C;
    localparam logic [7:0] T_CLASS_DATA     = 8'h01;
    localparam logic [7:0] T_CLASS_ID       = 8'h01;
    localparam logic [7:0] T_CLASS_SID      = 8'h02;
    localparam logic [7:0] L_CLASS_ID       = 8'h01;
    localparam logic [7:0] L_CLASS_SID      = 8'h02;
    localparam logic [7:0] L_CLASS_DATA     = 8'h07;
    localparam logic [7:0] CLASS_ID_MIN     = 8'h01;
    localparam logic [7:0] CLASS_ID_MAX     = 8'h10;
    localparam logic [7:0] CAP_OFF          = 8'h00;
    localparam int         MAX_CLASSES      = 16;
    localparam logic [3:0] ERR_NONE         = 4'h0;
    localparam logic [3:0] ERR_CLASSIFIER   = 4'h1;
    localparam logic [3:0] ERR_FLOW         = 4'h2;
    localparam logic [3:0] ERR_PHS          = 4'h4;
    localparam logic [3:0] ERR_RESOURCE     = 4'h8;
endpackage
`default_nettype wire

// File: hdl/reg_link_if.sv
// Purpose: link between head-end and modem for response and acknowledge
// Assumes: single clock, one octet per valid cycle
// Notes:   rsp_* carries response bytes; ack_* carries acknowledge fields
`default_nettype none
interface reg_link_if;
    logic        rsp_valid;
    logic [7:0]  rsp_byte;
    logic        rsp_last;
    logic [15:0] rsp_sid;
    logic [7:0]  rsp_conf;
    logic        rsp_done;
    logic        ack_valid;
    logic [15:0] ack_sid;
    logic [7:0]  ack_conf;
    logic [3:0]  ack_err_sets;
    logic [15:0] ack_err_flow;
    logic [15:0] ack_err_class;
    modport headend (output rsp_valid, rsp_byte, rsp_last, rsp_sid, rsp_conf, rsp_done,
                     input  ack_valid, ack_sid, ack_conf, ack_err_sets, ack_err_flow,
                            ack_err_class);
    modport modem   (input  rsp_valid, rsp_byte, rsp_last, rsp_sid, rsp_conf, rsp_done,
                     output ack_valid, ack_sid, ack_conf, ack_err_sets, ack_err_flow,
                            ack_err_class);
endinterface
`default_nettype wire

// File: hdl/reg_modem_ack.sv
// Purpose: modem end, answers a finished response with ok code with an acknowledge
// Assumes: failure flags from the user are stable while rsp_done pulses
// Notes:   one ack per response with ok code, or a negative ack on lack of resources
`default_nettype none
module reg_modem_ack
    import reg_tlv_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    reg_link_if.modem        link,
    input  wire logic        fail_classifier,
    input  wire logic        fail_flow,
    input  wire logic        fail_phs,
    input  wire logic        no_resources,
    input  wire logic        fail_id_given,
    input  wire logic [15:0] fail_flow_id,
    input  wire logic [15:0] fail_class_id,
    input  wire logic [15:0] fail_flow_ref,
    input  wire logic [15:0] fail_class_ref,
    output logic             ack_sent
);
    import reg_tlv_pkg::*;

    logic        ack_valid_reg;
    logic [15:0] ack_sid_reg;
    logic [7:0]  ack_conf_reg;
    logic [3:0]  ack_err_reg;
    logic [15:0] ack_flow_reg;
    logic [15:0] ack_class_reg;
    logic [3:0]  err_next;

    always_comb begin
        err_next = ERR_NONE;
        if (fail_classifier) err_next = err_next | ERR_CLASSIFIER;
        if (fail_flow) err_next = err_next | ERR_FLOW;
        if (fail_phs) err_next = err_next | ERR_PHS;
        if (no_resources) err_next = err_next | ERR_RESOURCE;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_valid_reg <= 1'b0;
            ack_sid_reg   <= 16'h0000;
            ack_conf_reg  <= CONF_OK;
            ack_err_reg   <= ERR_NONE;
            ack_flow_reg  <= 16'h0000;
            ack_class_reg <= 16'h0000;
        end else begin
            ack_valid_reg <= link.rsp_done && (link.rsp_conf == CONF_OK);
            if (link.rsp_done) begin
                ack_sid_reg  <= link.rsp_sid;
                ack_conf_reg <= no_resources ? CONF_REJECT : CONF_OK;
                ack_err_reg  <= err_next;
                ack_flow_reg <= fail_id_given ? fail_flow_id : fail_flow_ref;
                ack_class_reg <= fail_id_given ? fail_class_id : fail_class_ref;
            end
        end
    end

    assign link.ack_valid     = ack_valid_reg;
    assign link.ack_sid       = ack_sid_reg;
    assign link.ack_conf      = ack_conf_reg;
    assign link.ack_err_sets  = ack_err_reg;
    assign link.ack_err_flow  = ack_flow_reg;
    assign link.ack_err_class = ack_class_reg;
    assign ack_sent           = ack_valid_reg;
endmodule
`default_nettype wire

// File: hdl/reg_headend_rsp.sv
// Purpose: head-end end, frames capability echo and class data tlvs of the response
// Assumes: request content is presented by the user as a start pulse plus tables
// Notes:   one octet per cycle on the link; checks the returning acknowledge
`default_nettype none
// What this block and the modem end do
// - unknown capability echoed with value zero
// - capability on only if request on
// - one class data tlv per request class
// - each class data tlv holds one class
// - missing class id gives failure, capability tlv only, no class data tlvs
// - class data tlv type 1, length n
// - class id sub-tlv 1.1, length 1, 1..16
// - class id must be one requested
// - sid sub-tlv 1.2, length 2, assigned sid
// - modem acks an ok response
// - ack carries response sid
// - one confirmation code per ack
// - ack carries error sets for failures
// - error sets use ids, else references
// - classifier error set for failed classifier
// - flow error set for failed qos parameter
// - suppression error set for failed rule
// - no error sets on full success
// - modem may nak on lacking resources
// - type and length one octet each
module reg_headend_rsp
    import reg_tlv_pkg::*;
#(
    parameter int NCLS = MAX_CLASSES
)(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    reg_link_if.headend            link,
    input  wire logic              start,
    input  wire logic [15:0]       rsp_sid_in,
    input  wire logic [7:0]        cap_type,
    input  wire logic              cap_req_on,
    input  wire logic              cap_known,
    input  wire logic              cap_grant,
    input  wire logic [NCLS-1:0]   cls_present,
    input  wire logic [NCLS-1:0]   cls_id_ok,
    input  wire logic [NCLS*8-1:0] cls_id,
    input  wire logic [NCLS*16-1:0] cls_sid,
    output logic                   busy,
    output logic                   cos_fail,
    output logic                   ack_ok,
    output logic                   ack_bad_sid,
    output logic [7:0]             ack_conf_out
);
    import reg_tlv_pkg::*;

    typedef enum {S_IDLE, S_CAP_T, S_CAP_L, S_CAP_V, S_CD_T, S_CD_L,
                  S_ID_T, S_ID_L, S_ID_V, S_SID_T, S_SID_L, S_SID_H, S_SID_LO,
                  S_DONE} state_t;

    state_t      state_reg;
    logic [4:0]  idx_reg;
    logic        valid_reg;
    logic [7:0]  byte_reg;
    logic        last_reg;
    logic [15:0] sid_reg;
    logic [7:0]  conf_reg;
    logic        done_reg;
    logic        fail_reg;
    logic        pending_reg;
    logic        ack_ok_reg;
    logic        ack_bad_reg;
    logic [7:0]  ack_conf_reg;
    logic [7:0]  cur_id;
    logic [15:0] cur_sid;
    logic        any_missing;
    logic        id_range_ok;

    function automatic logic [4:0] next_cls(input logic [4:0] from,
                                            input logic [NCLS-1:0] pres);
        logic [4:0] r;
        r = 5'(NCLS);
        for (int i = NCLS - 1; i >= 0; i--) begin
            if (pres[i] && (5'(i) >= from)) r = 5'(i);
        end
        return r;
    endfunction

    assign cur_id      = cls_id[idx_reg[3:0]*8 +: 8];
    assign cur_sid     = cls_sid[idx_reg[3:0]*16 +: 16];
    assign any_missing = |(cls_present & ~cls_id_ok);
    assign id_range_ok = (cur_id >= CLASS_ID_MIN) && (cur_id <= CLASS_ID_MAX);

    // ----------------------------------------
    // response framer
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
            idx_reg   <= 5'h00;
            valid_reg <= 1'b0;
            byte_reg  <= 8'h00;
            last_reg  <= 1'b0;
            sid_reg   <= 16'h0000;
            conf_reg  <= CONF_OK;
            done_reg  <= 1'b0;
            fail_reg  <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            last_reg  <= 1'b0;
            done_reg  <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (start) begin
                        sid_reg   <= rsp_sid_in;
                        fail_reg  <= any_missing;
                        conf_reg  <= any_missing ? CONF_COS_FAIL : CONF_OK;
                        idx_reg   <= next_cls(5'h00, cls_present);
                        state_reg <= S_CAP_T;
                    end
                end
                S_CAP_T: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= cap_type;
                    state_reg <= S_CAP_L;
                end
                S_CAP_L: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= L_CLASS_ID;
                    state_reg <= S_CAP_V;
                end
                S_CAP_V: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= (cap_known && cap_req_on && cap_grant) ? 8'h01 : CAP_OFF;
                    last_reg  <= fail_reg || (idx_reg == 5'(NCLS));
                    state_reg <= (fail_reg || idx_reg == 5'(NCLS)) ? S_DONE : S_CD_T;
                end
                S_CD_T: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= T_CLASS_DATA;
                    state_reg <= S_CD_L;
                end
                S_CD_L: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= L_CLASS_DATA;
                    state_reg <= S_ID_T;
                end
                S_ID_T: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= T_CLASS_ID;
                    state_reg <= S_ID_L;
                end
                S_ID_L: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= L_CLASS_ID;
                    state_reg <= S_ID_V;
                end
                S_ID_V: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= cur_id;
                    if (!id_range_ok) conf_reg <= CONF_COS_FAIL;
                    state_reg <= S_SID_T;
                end
                S_SID_T: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= T_CLASS_SID;
                    state_reg <= S_SID_L;
                end
                S_SID_L: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= L_CLASS_SID;
                    state_reg <= S_SID_H;
                end
                S_SID_H: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= cur_sid[15:8];
                    state_reg <= S_SID_LO;
                end
                S_SID_LO: begin
                    valid_reg <= 1'b1;
                    byte_reg  <= cur_sid[7:0];
                    idx_reg   <= next_cls(idx_reg + 5'h01, cls_present);
                    if (next_cls(idx_reg + 5'h01, cls_present) == 5'(NCLS)) begin
                        last_reg  <= 1'b1;
                        state_reg <= S_DONE;
                    end else begin
                        state_reg <= S_CD_T;
                    end
                end
                S_DONE: begin
                    done_reg  <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // acknowledge check
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending_reg  <= 1'b0;
            ack_ok_reg   <= 1'b0;
            ack_bad_reg  <= 1'b0;
            ack_conf_reg <= CONF_OK;
        end else begin
            ack_ok_reg  <= 1'b0;
            ack_bad_reg <= 1'b0;
            if (link.ack_valid && (!pending_reg || link.ack_sid != sid_reg)) begin
                ack_bad_reg <= 1'b1;
            end else if (link.ack_valid) begin
                ack_ok_reg   <= 1'b1;
                ack_conf_reg <= link.ack_conf;
                pending_reg  <= 1'b0;
            end
            if (done_reg && conf_reg == CONF_OK) pending_reg <= 1'b1;
        end
    end

    assign link.rsp_valid = valid_reg;
    assign link.rsp_byte  = byte_reg;
    assign link.rsp_last  = last_reg;
    assign link.rsp_sid   = sid_reg;
    assign link.rsp_conf  = conf_reg;
    assign link.rsp_done  = done_reg;
    assign busy           = (state_reg != S_IDLE);
    assign cos_fail       = (conf_reg == CONF_COS_FAIL);
    assign ack_ok         = ack_ok_reg;
    assign ack_bad_sid    = ack_bad_reg;
    assign ack_conf_out   = ack_conf_reg;
endmodule
`default_nettype wire

// File: bench/reg_link_props.sv
// Purpose: wire checks on the response and acknowledge link
// Assumes: one clock, synchronous active high reset
// Notes:   watches the link between the two design ends only
`default_nettype none
module reg_link_props
    import reg_tlv_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_byte,
    input wire logic        rsp_last,
    input wire logic [15:0] rsp_sid,
    input wire logic [7:0]  rsp_conf,
    input wire logic        rsp_done,
    input wire logic        ack_valid,
    input wire logic [15:0] ack_sid,
    input wire logic [7:0]  ack_conf,
    input wire logic [3:0]  ack_err_sets
);
    timeunit 1ns;
    timeprecision 1ps;
    // byte position within the current frame
    logic [7:0] pos_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge sys_clk) begin
        if (rst || (rsp_valid && rsp_last)) begin
            pos_reg <= 8'h00;
        end else if (rsp_valid) begin
            pos_reg <= pos_reg + 8'h01;
        end
    end
    a_frame_done: assert property (rsp_valid && rsp_last |=> rsp_done && !rsp_valid)
        else $error("done does not follow last byte");
    a_bytes_packed: assert property (rsp_valid && !rsp_last |=> rsp_valid)
        else $error("gap inside a frame");
    a_cap_len: assert property (rsp_valid && pos_reg == 8'h01 |-> rsp_byte == 8'h01)
        else $error("capability length is not one");
    a_class_hdr: assert property (rsp_valid && pos_reg == 8'h03 |->
        rsp_byte == T_CLASS_DATA ##1 rsp_byte == L_CLASS_DATA)
        else $error("class data header wrong");
    a_id_sub: assert property (rsp_valid && pos_reg == 8'h05 |->
        rsp_byte == T_CLASS_ID ##1 rsp_byte == L_CLASS_ID)
        else $error("class id sub header wrong");
    a_sid_sub: assert property (rsp_valid && pos_reg == 8'h08 |->
        rsp_byte == T_CLASS_SID ##1 rsp_byte == L_CLASS_SID)
        else $error("sid sub header wrong");
    a_ack_on_ok: assert property (rsp_done && rsp_conf == CONF_OK |=> ack_valid)
        else $error("no ack after ok response");
    a_ack_sid_echo: assert property (rsp_done && rsp_conf == CONF_OK |=>
        ack_sid == $past(rsp_sid))
        else $error("ack sid differs from response sid");
    a_no_ack_bad: assert property (rsp_done && rsp_conf != CONF_OK |=> !ack_valid[*2])
        else $error("ack after failed response");
    a_ack_once: assert property (ack_valid |=> !ack_valid[*2])
        else $error("more than one ack");
    a_clean_ok: assert property (ack_valid && ack_err_sets == ERR_NONE |->
        ack_conf == CONF_OK)
        else $error("clean ack without ok code");
    a_nak_res: assert property (ack_valid && ack_err_sets[3] |-> ack_conf == CONF_REJECT)
        else $error("resource failure without reject");
endmodule
`default_nettype wire

// File: bench/registration_response_ack_tlv_bench.sv
// Purpose: self-checking bench for the response framer and acknowledge end
// Assumes: two classes; class ids, sids and capability type driven by the bench
// Notes:   a second head-end faces a bench driver for bad acks
`default_nettype none
module registration_response_ack_tlv_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import reg_tlv_pkg::*;
    typedef struct packed {
        logic k, q, g;
        logic [1:0] p, ok;
        logic [3:0] f;
        logic idg;
    } row_t;
    row_t rows [5] = '{'{1'b1, 1'b1, 1'b1, 2'b00, 2'b00, 4'h0, 1'b0},
        '{1'b0, 1'b1, 1'b1, 2'b01, 2'b01, 4'h1, 1'b1},
        '{1'b1, 1'b0, 1'b1, 2'b11, 2'b11, 4'h6, 1'b0},
        '{1'b1, 1'b1, 1'b0, 2'b10, 2'b11, 4'h8, 1'b1},
        '{1'b1, 1'b1, 1'b1, 2'b11, 2'b10, 4'h0, 1'b0}};
    logic sys_clk = 0, rst = 1, start = 0, start2 = 0, k = 0, q = 0, g = 0, idg = 0;
    logic [1:0] p = 0, ok = 0;
    logic [3:0] f = 0, sets_s;
    logic [15:0] sid = 0, fid = 0, cid = 0, fref = 0, cref = 0, sid_s, flow_s, cls_s;
    logic [7:0] conf_s, exp_q[$], got[$];
    logic busy, cos_fail, ack_ok, ack_bad, bad2, sent, ok2;
    logic [7:0] conf_out, conf2, cap_t = 8'h05;
    logic [15:0] cls_ids = 16'h1003;
    logic [31:0] cls_sids = 32'h0abc_1234;
    int num_errors = 0, check_count = 0, acks = 0, oks = 0, bads = 0, lasts = 0;
    int sents = 0, oks2 = 0;
    reg_link_if link_i ();
    reg_link_if link2_i ();
    always #2 sys_clk = ~sys_clk;
    reg_headend_rsp #(.NCLS(2)) reg_headend_rsp_i (.sys_clk(sys_clk), .rst(rst),
        .link(link_i), .start(start), .rsp_sid_in(sid), .cap_type(cap_t), .cap_req_on(q),
        .cap_known(k), .cap_grant(g), .cls_present(p), .cls_id_ok(ok),
        .cls_id(cls_ids), .cls_sid(cls_sids), .busy(busy), .cos_fail(cos_fail),
        .ack_ok(ack_ok), .ack_bad_sid(ack_bad), .ack_conf_out(conf_out));
    reg_headend_rsp #(.NCLS(2)) reg_headend_rsp_i2 (.sys_clk(sys_clk), .rst(rst),
        .link(link2_i), .start(start2), .rsp_sid_in(sid), .cap_type(cap_t),
        .cap_req_on(q), .cap_known(k), .cap_grant(g), .cls_present(p), .cls_id_ok(ok),
        .cls_id(cls_ids), .cls_sid(cls_sids), .busy(), .cos_fail(),
        .ack_ok(ok2), .ack_bad_sid(bad2), .ack_conf_out(conf2));
    reg_modem_ack reg_modem_ack_i (.sys_clk(sys_clk), .rst(rst), .link(link_i),
        .fail_classifier(f[0]), .fail_flow(f[1]), .fail_phs(f[2]), .no_resources(f[3]),
        .fail_id_given(idg), .fail_flow_id(fid), .fail_class_id(cid),
        .fail_flow_ref(fref), .fail_class_ref(cref), .ack_sent(sent));
    reg_link_props reg_link_props_i (.sys_clk(sys_clk), .rst(rst),
        .rsp_valid(link_i.rsp_valid), .rsp_byte(link_i.rsp_byte),
        .rsp_last(link_i.rsp_last), .rsp_sid(link_i.rsp_sid), .rsp_conf(link_i.rsp_conf),
        .rsp_done(link_i.rsp_done), .ack_valid(link_i.ack_valid),
        .ack_sid(link_i.ack_sid), .ack_conf(link_i.ack_conf),
        .ack_err_sets(link_i.ack_err_sets));
    // -----------------------------------------------------------------
    // monitor
    // -----------------------------------------------------------------
    // sampled mid-cycle so flop outputs are settled
    always @(negedge sys_clk) begin
        if (link_i.rsp_valid) got.push_back(link_i.rsp_byte);
        if (sent) sents++;
        if (ok2) oks2++;
        if (link_i.rsp_valid && link_i.rsp_last) lasts++;
        if (link_i.ack_valid) begin
            acks++;
            {sid_s, conf_s, sets_s} = {link_i.ack_sid, link_i.ack_conf, link_i.ack_err_sets};
            {flow_s, cls_s} = {link_i.ack_err_flow, link_i.ack_err_class};
        end
        if (ack_ok) oks++;
        if (bad2) bads++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // one response and its acknowledge
    // -----------------------------------------------------------------
    task automatic run_row(input row_t r, input int i, input int hold);
        int a0, o0, s0;
        logic good, inr;
        a0 = acks;
        o0 = oks;
        s0 = sents;
        got.delete();
        @(posedge sys_clk);
        good = &(~r.p | r.ok);
        inr = 1'b1;
        exp_q = '{cap_t, 8'h01, {7'h00, r.k & r.q & r.g}};
        for (int c = 0; c < 2; c++) begin
            if (good && r.p[c]) begin
                exp_q = {exp_q, 8'h01, 8'h07, 8'h01, 8'h01, cls_ids[c*8 +: 8], 8'h02,
                    8'h02, cls_sids[c*16+8 +: 8], cls_sids[c*16 +: 8]};
                if (cls_ids[c*8 +: 8] < CLASS_ID_MIN || cls_ids[c*8 +: 8] > CLASS_ID_MAX)
                    inr = 1'b0;
            end
        end
        {k, q, g, p, ok, f, idg} <= r;
        {sid, fid, cid} <= {16'h5a00 + 16'(i), 16'h1100 + 16'(i), 16'h3300 + 16'(i)};
        {fref, cref} <= {16'h2200 + 16'(i), 16'h4400 + 16'(i)};
        start <= 1;
        repeat (hold) @(posedge sys_clk);
        start <= 0;
        for (int n = 0; n < 60 && !link_i.rsp_done; n++) @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        check(got.size(), exp_q.size());
        foreach (exp_q[j]) check(got[j], exp_q[j]);
        check(got[1], 8'h01);
        check(got[2], {7'h00, r.k & r.q & r.g});
        check(cos_fail, !(good && inr));
        check(acks - a0, good && inr);
        check(sents - s0, good && inr);
        if (good && inr) begin
            check(sid_s, 16'h5a00 + 16'(i));
            check(sets_s, r.f);
            check(sets_s[0], r.f[0]);
            check(sets_s[1], r.f[1]);
            check(sets_s[2], r.f[2]);
            if (r.f == 4'h0) check(sets_s, ERR_NONE);
            check(conf_s, r.f[3] ? CONF_REJECT : CONF_OK);
            check(oks - o0, 1);
            check(conf_out, r.f[3] ? CONF_REJECT : CONF_OK);
            if (r.f != 0) check({flow_s, cls_s}, r.idg ? {fid, cid} : {fref, cref});
        end
        $display("test %0d done", i);
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end
    initial begin
        {link2_i.ack_valid, link2_i.ack_sid, link2_i.ack_conf} = '0;
        {link2_i.ack_err_sets, link2_i.ack_err_flow, link2_i.ack_err_class} = '0;
        repeat (16) @(posedge sys_clk);
        rst <= 0;
        check({busy, ack_ok, link_i.rsp_valid}, 3'b000);
        foreach (rows[i]) run_row(rows[i], i, 1);
        run_row(rows[0], 5, 2);
        // class id out of range: still framed, but the response fails and is not acked
        cls_ids <= 16'h1000;
        cap_t <= 8'h07;
        run_row(rows[2], 6, 1);
        cls_ids <= 16'h1003;
        check(lasts, 7);
        // a stray ack on the second link must be flagged
        @(posedge sys_clk);
        link2_i.ack_valid <= 1;
        link2_i.ack_sid <= 16'hdead;
        @(posedge sys_clk);
        link2_i.ack_valid <= 0;
        repeat (3) @(posedge sys_clk);
        check(bads, 1);
        $display("test stray ack done");
        // with a response pending, a wrong sid is flagged and the right one is taken
        start2 <= 1;
        @(posedge sys_clk);
        start2 <= 0;
        repeat (40) @(posedge sys_clk);
        link2_i.ack_valid <= 1;
        link2_i.ack_sid <= 16'hdead;
        link2_i.ack_conf <= CONF_REJECT;
        @(posedge sys_clk);
        link2_i.ack_sid <= sid;
        @(posedge sys_clk);
        link2_i.ack_valid <= 0;
        repeat (3) @(posedge sys_clk);
        check(bads, 2);
        check(oks2, 1);
        check(conf2, CONF_REJECT);
        $display("test pending ack done");
        start <= 1;
        @(posedge sys_clk);
        start <= 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        check({busy, link_i.rsp_valid, link_i.ack_valid}, 3'b000);
        $display("test mid reset done");
        close_out();
    end
endmodule
`default_nettype wire
